/* File: rtl/e1mfa_top.sv */
// Design decisions made here: the placing of the registers and the strobed register port.
module e1mfa_top (
  input  wire logic       clock_i,        // 40 MHz
  input  wire logic       reset_i,        // Sync, active high
  input  wire logic [1:0] addr_i,         // Register index
  input  wire logic [7:0] wdata_i,        // Write data
  input  wire logic       wr_i,           // Write strobe
  input  wire logic       rd_i,           // Read strobe
  output logic      [7:0] rdata_o,        // Read data, next cycle
  input  wire logic       frame_i,        // Primary frame strobe
  input  wire logic [7:0] ts16_i,         // Slot 16 octet, bit 1 = msb
  input  wire logic       basic_aligned_i,// Primary basic alignment
  input  wire logic       loss_fas_i,     // Loss by framing bits
  input  wire logic       loss_crc915_i,  // Loss by 915/1000
  input  wire logic       reframe_req_i,  // On-demand reframe
  input  wire logic       path_reconfig_i,// Path reconfigured
  input  wire logic       cand_frame_i,   // Candidate frame strobe
  input  wire logic       cand_nfas_i,    // Candidate frame is non-FAS
  input  wire logic       cand_bit1_i,    // Candidate slot 0 bit 1
  input  wire logic       cand_differs_i, // Candidate differs from primary
  input  wire logic       tx_frame_i,     // Transmit frame strobe
  input  wire logic       tx_fas_i,       // Transmit frame is FAS
  output logic            new_search_o,   // Start parallel basic search
  output logic            adopt_cand_o,   // Replace primary by candidate
  output logic            crc4_mfa_o,     // CRC-4 multiframe aligned
  output logic            crc4_inhibit_o, // Receive CRC-4 inhibited
  output logic            e_bits_zero_o,  // Send both E bits zero
  output logic            sig_update_o,   // Signaling octet valid
  output logic      [2:0] rx_ctrl_o,      // Received spare bits
  output logic            rx_far_alarm_o, // Received remote alarm
  output logic      [7:0] tx_ts16_f0_o,   // Transmit frame 0 octet
  output logic            tx_mf_start_o,  // Transmit frame 0 now
  output logic            sys_ts16_ais_o  // AIS into system slot 16
);
  logic [7:0]  reframe_mode_config;
  logic [7:0]  signaling_spare_alarm_cfg;
  logic [7:0]  system_ts16_alarm_config;
  e1mfa_pkg::e1mfa_crc_e crc_st;
  e1mfa_pkg::e1mfa_sig_e sig_st;
  logic        iw_en;
  logic        crc4_mode;
  logic        tmr_kill;
  logic        basic_loss;
  logic        basic_prev;
  logic        tmr_armed;
  logic        tmr_run;
  logic [11:0] tmr_cnt;
  logic        tmr_exp;
  logic [5:0]  mfa_sh;
  logic        mfa_hit;
  logic [5:0]  win;
  logic        have_hit;
  logic [3:0]  hit_phase;
  logic        mfa_found;
  logic        win_end;
  logic [3:0]  mf_cnt;
  logic        prev_one;
  logic        bad_f0;
  logic        bad_prev;
  logic [5:0]  zero_cnt;
  logic        sig_loss;
  logic [3:0]  tx_cnt;
  logic        sig_lost;

  assign crc4_mode = reframe_mode_config[e1mfa_pkg::RF_CRC4];
  // 100 ms select bit is not looked at here
  assign iw_en = crc4_mode & reframe_mode_config[e1mfa_pkg::RF_IWK] &
                 ~reframe_mode_config[e1mfa_pkg::RF_OFF];  // [R1] [R2]
  assign basic_loss = loss_fas_i | loss_crc915_i | ~basic_aligned_i;
  assign tmr_kill = loss_fas_i | loss_crc915_i | reframe_req_i | ~crc4_mode |
                    path_reconfig_i;  // [R6] [R12]
  assign tmr_exp = tmr_run & frame_i &
                   (tmr_cnt == 12'(e1mfa_pkg::IWT_FRAMES - 1));  // [R26]
  assign mfa_hit = cand_frame_i & cand_nfas_i &
                   ({mfa_sh[4:0], cand_bit1_i} == e1mfa_pkg::MFA_PATTERN);  // [R25]
  assign mfa_found = mfa_hit & have_hit & (win[3:0] == hit_phase);  // [R24]
  assign win_end = cand_frame_i & (win == 6'(e1mfa_pkg::SRCH_FRAMES - 1));
  assign sig_lost = (sig_st != e1mfa_pkg::SS_ALGN);

  // Register port
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      reframe_mode_config       <= e1mfa_pkg::RST_CFG;
      signaling_spare_alarm_cfg <= e1mfa_pkg::RST_CFG;
      system_ts16_alarm_config  <= e1mfa_pkg::RST_CFG;
    end else if (wr_i) begin
      case (addr_i)
        e1mfa_pkg::ADDR_REFRAME: reframe_mode_config       <= wdata_i;
        e1mfa_pkg::ADDR_SIGCFG:  signaling_spare_alarm_cfg <= wdata_i;
        e1mfa_pkg::ADDR_SYSCFG:  system_ts16_alarm_config  <= wdata_i;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        e1mfa_pkg::ADDR_REFRAME: rdata_o <= reframe_mode_config;
        e1mfa_pkg::ADDR_SIGCFG:  rdata_o <= signaling_spare_alarm_cfg;
        e1mfa_pkg::ADDR_SYSCFG:  rdata_o <= system_ts16_alarm_config;
        default: begin
          rdata_o <= 8'h00;
          rdata_o[e1mfa_pkg::ST_SIG_LOST] <= sig_lost;  // [R18]
          rdata_o[e1mfa_pkg::ST_CRC_LOST] <= (crc_st != e1mfa_pkg::CS_ALGN);
          rdata_o[e1mfa_pkg::ST_IWK] <= (crc_st == e1mfa_pkg::CS_IWK);  // [R3]
        end
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // Interworking timer
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      basic_prev <= 1'b0;
      tmr_armed  <= 1'b1;
      tmr_run    <= 1'b0;
      tmr_cnt    <= 12'h000;
    end else begin
      basic_prev <= basic_aligned_i;
      if (tmr_kill) begin  // [R6]
        tmr_armed <= 1'b1;
        tmr_run   <= 1'b0;
        tmr_cnt   <= 12'h000;
      end else if (basic_aligned_i & ~basic_prev & tmr_armed & iw_en) begin  // [R5]
        tmr_armed <= 1'b0;
        tmr_run   <= 1'b1;
        tmr_cnt   <= 12'h000;
      end else if (tmr_exp | (crc_st == e1mfa_pkg::CS_ALGN)) begin
        tmr_run <= 1'b0;
      end else if (tmr_run & frame_i) begin  // [R26]
        tmr_cnt <= tmr_cnt + 12'h001;
      end
    end
  end

  // CRC-4 multiframe search on the candidate alignment
  always_ff @(posedge clock_i) begin
    if (reset_i || crc_st != e1mfa_pkg::CS_SRCH) begin
      mfa_sh    <= 6'h3f;
      win       <= 6'h00;
      have_hit  <= 1'b0;
      hit_phase <= 4'h0;
    end else if (win_end & ~mfa_found) begin  // [R8] [R9]
      mfa_sh    <= 6'h3f;
      win       <= 6'h00;
      have_hit  <= 1'b0;
    end else if (cand_frame_i) begin
      win <= win + 6'h01;
      if (cand_nfas_i) begin
        mfa_sh <= {mfa_sh[4:0], cand_bit1_i};
      end
      if (mfa_hit & ~mfa_found) begin
        have_hit  <= 1'b1;
        hit_phase <= win[3:0];
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i || path_reconfig_i) begin  // [R12]
      crc_st <= e1mfa_pkg::CS_LOST;
    end else if (basic_loss | ~crc4_mode | reframe_req_i) begin  // [R7] [R23]
      crc_st <= e1mfa_pkg::CS_LOST;
    end else begin
      case (crc_st)
        e1mfa_pkg::CS_LOST: crc_st <= e1mfa_pkg::CS_SRCH;  // [R23]
        e1mfa_pkg::CS_SRCH: begin
          if (mfa_found) begin
            crc_st <= e1mfa_pkg::CS_ALGN;  // [R11]
          end else if (tmr_exp & iw_en) begin
            crc_st <= e1mfa_pkg::CS_IWK;  // [R3]
          end
        end
        e1mfa_pkg::CS_ALGN: crc_st <= e1mfa_pkg::CS_ALGN;
        e1mfa_pkg::CS_IWK:  crc_st <= e1mfa_pkg::CS_IWK;
        default:            crc_st <= e1mfa_pkg::CS_LOST;
      endcase
    end
  end

  // Search side outputs; traffic stays on primary until adopt
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      new_search_o   <= 1'b0;
      adopt_cand_o   <= 1'b0;
      crc4_mfa_o     <= 1'b0;
      crc4_inhibit_o <= 1'b0;
      e_bits_zero_o  <= 1'b0;
    end else begin
      new_search_o <= (crc_st == e1mfa_pkg::CS_SRCH) & win_end & ~mfa_found &
                      ~basic_loss;  // [R8]
      adopt_cand_o <= (crc_st == e1mfa_pkg::CS_SRCH) & mfa_found &
                      cand_differs_i & ~basic_loss;  // [R10] [R11]
      crc4_mfa_o     <= (crc_st == e1mfa_pkg::CS_ALGN);
      crc4_inhibit_o <= (crc_st == e1mfa_pkg::CS_IWK);  // [R3]
      e_bits_zero_o  <= (crc_st == e1mfa_pkg::CS_IWK);  // [R4]
    end
  end

  // Slot 16 signaling multiframe receive
  assign bad_f0 = frame_i & (mf_cnt == 4'h0) & (ts16_i[7:4] != e1mfa_pkg::TS16_ALIGN);
  assign sig_loss = basic_loss | path_reconfig_i | (bad_f0 & bad_prev) |
                    (frame_i & (ts16_i == 8'h00) &
                     (zero_cnt == 6'(e1mfa_pkg::ZERO_FRAMES - 1)));  // [R17]

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      prev_one <= 1'b0;
      zero_cnt <= 6'h00;
    end else if (frame_i) begin
      prev_one <= (ts16_i != 8'h00);
      if (ts16_i != 8'h00 || sig_lost) begin
        zero_cnt <= 6'h00;
      end else if (zero_cnt != 6'(e1mfa_pkg::ZERO_FRAMES - 1)) begin
        zero_cnt <= zero_cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      sig_st   <= e1mfa_pkg::SS_LOST;
      mf_cnt   <= 4'h0;
      bad_prev <= 1'b0;
    end else begin
      case (sig_st)
        e1mfa_pkg::SS_LOST: begin
          bad_prev <= 1'b0;
          if (frame_i & basic_aligned_i & ~path_reconfig_i & prev_one &
              (ts16_i[7:4] == e1mfa_pkg::TS16_ALIGN)) begin  // [R22]
            sig_st <= e1mfa_pkg::SS_ALGN;
            mf_cnt <= 4'h1;
          end
        end
        e1mfa_pkg::SS_ALGN: begin
          if (sig_loss) begin  // [R17]
            sig_st <= e1mfa_pkg::SS_LOST;
          end else if (frame_i) begin
            mf_cnt <= mf_cnt + 4'h1;  // [R13]
            if (mf_cnt == 4'h0) begin
              bad_prev <= bad_f0;
            end
          end
        end
        default: sig_st <= e1mfa_pkg::SS_LOST;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      sig_update_o   <= 1'b0;
      rx_ctrl_o      <= 3'h7;
      rx_far_alarm_o <= 1'b0;
    end else if (sig_lost | sig_loss) begin  // [R19]
      sig_update_o   <= 1'b0;
      rx_ctrl_o      <= 3'h7;
      rx_far_alarm_o <= 1'b0;
    end else begin
      sig_update_o <= frame_i & (mf_cnt != 4'h0);  // [R13]
      if (frame_i & (mf_cnt == 4'h0)) begin
        rx_ctrl_o      <= {ts16_i[3], ts16_i[1], ts16_i[0]};  // [R14]
        rx_far_alarm_o <= ts16_i[2];
      end
    end
  end

  // Slot 16 signaling multiframe transmit, free of CRC-4 phase
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      tx_cnt        <= 4'h0;
      tx_mf_start_o <= 1'b0;
    end else begin
      tx_mf_start_o <= tx_frame_i & (tx_cnt == 4'h0) &
                       (tx_fas_i != signaling_spare_alarm_cfg[e1mfa_pkg::SC_NONFAS]);  // [R15]
      if (tx_frame_i) begin
        if (tx_cnt == 4'h0 && tx_fas_i == signaling_spare_alarm_cfg[e1mfa_pkg::SC_NONFAS]) begin
          tx_cnt <= 4'h0;  // [R15] [R16]
        end else begin
          tx_cnt <= tx_cnt + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      tx_ts16_f0_o   <= 8'h00;
      sys_ts16_ais_o <= 1'b0;
    end else begin
      tx_ts16_f0_o <= {e1mfa_pkg::TS16_ALIGN, signaling_spare_alarm_cfg[0],
                       sig_lost & signaling_spare_alarm_cfg[e1mfa_pkg::SC_ALARM],
                       signaling_spare_alarm_cfg[1], signaling_spare_alarm_cfg[2]};  // [R14] [R20]
      sys_ts16_ais_o <= sig_lost &
                        system_ts16_alarm_config[e1mfa_pkg::SY_AIS];  // [R21]
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  chk_iwk_after_exp: assert property ( // [R3]
    (crc_st == e1mfa_pkg::CS_SRCH) && tmr_exp && iw_en && !mfa_found && !basic_loss &&
    !path_reconfig_i && !reframe_req_i && crc4_mode |=> ##1 crc4_inhibit_o && e_bits_zero_o)
    else $error("interworking not entered at timer expiry");
  chk_timer_start: assert property ( // [R5]
    basic_aligned_i && !basic_prev && tmr_armed && iw_en && !tmr_kill |=> tmr_run && tmr_cnt == 12'h000)
    else $error("timer did not start on first alignment");
  chk_timer_hold: assert property ( // [R8]
    new_search_o |-> $stable(tmr_cnt) || tmr_cnt == $past(tmr_cnt) + 12'h001)
    else $error("parallel search disturbed timer");
  chk_timer_kill: assert property ( // [R6]
    loss_fas_i || reframe_req_i |=> !tmr_run && tmr_cnt == 12'h000)
    else $error("timer not reset on kill event");
  chk_basic_loss: assert property ( // [R23]
    !basic_aligned_i |=> crc_st == e1mfa_pkg::CS_LOST ##1 !crc4_mfa_o)
    else $error("basic loss did not drop multiframe alignment");
  chk_sig_forced: assert property ( // [R19]
    sig_lost |=> rx_ctrl_o == 3'h7 && !rx_far_alarm_o && !sig_update_o)
    else $error("lost signaling outputs not forced");
  chk_sig_alarm_tx: assert property ( // [R20]
    sig_lost && signaling_spare_alarm_cfg[e1mfa_pkg::SC_ALARM] |=> tx_ts16_f0_o[2])
    else $error("remote multiframe alarm not sent");
  chk_sys_ais: assert property ( // [R21]
    $past(sig_lost) && $past(system_ts16_alarm_config[e1mfa_pkg::SY_AIS]) |-> sys_ts16_ais_o)
    else $error("system slot 16 AIS missing");
  chk_two_bad_f0: assert property ( // [R17]
    sig_st == e1mfa_pkg::SS_ALGN && bad_f0 && bad_prev |=> sig_lost)
    else $error("two bad alignment patterns ignored");
  chk_align_ts16: assert property ( // [R22]
    sig_lost && frame_i && basic_aligned_i && !path_reconfig_i && prev_one && ts16_i[7:4] == 4'h0
    |=> !sig_lost)
    else $error("signaling alignment not declared");
  cov_mfa_found: cover property (crc_st == e1mfa_pkg::CS_SRCH ##1 crc_st == e1mfa_pkg::CS_ALGN);
  cov_iwk: cover property (crc_st == e1mfa_pkg::CS_SRCH ##1 crc_st == e1mfa_pkg::CS_IWK);
  cov_new_search: cover property (new_search_o);
  cov_sig_lost: cover property (sig_st == e1mfa_pkg::SS_ALGN ##1 sig_lost);
endmodule

/* File: rtl/e1mfa_pkg.sv */
// Behaviour
// R1 - Interworking search with 400 ms timer when reframe config matches 0XXX1XX1.
// R2 - Interworking search wins over the 100 ms timer mode when both selected.
// R3 - Timer expiry without multiframe alignment flags no alignment, inhibits receive CRC-4.
// R4 - After expiry the transmitter keeps CRC-4 format with both E bits zero.
// R5 - Timer starts when primary basic frame alignment is first recovered.
// R6 - Timer resets only on framing loss, 915/1000 loss, reframe request, non-CRC-4 mode; the code also resets it on path reconfiguration.
// R7 - Primary basic frame loss checking runs continuously in every search state.
// R8 - No alignment in 8 ms starts a parallel basic search, timer untouched.
// R9 - Parallel searches are independent; later multiframe searches use the found candidate.
// R10 - Traffic keeps following the primary alignment during multiframe search.
// R11 - Alignment found before expiry adopts its candidate when it differs from primary.
// R12 - Path reconfiguration resets the whole interworking algorithm.
// R13 - Signaling multiframe is 16 frames; frame 0 bits 1-4 all zero.
// R14 - Frame 0 bits 5,7,8 are spare config bits 0-2; bit 6 is remote alarm.
// R15 - Signaling option places the transmit alignment pattern in FAS or non-FAS frame.
// R16 - Transmit signaling multiframe has no fixed phase to the CRC-4 multiframe.
// R17 - Signaling alignment lost on basic loss, two bad patterns, or two all-zero multiframes.
// R18 - Signaling alignment loss shows in bit 1 of the first status register.
// R19 - While lost: freeze signaling, control bits forced one, remote alarm status zero.
// R20 - While lost, send remote multiframe alarm when signaling config bit 4 is set.
// R21 - While lost, insert AIS in system transmit slot 16 when config bit 6 set.
// R22 - Signaling alignment on first 0000 after a slot 16 holding a one.
// R23 - Basic frame loss forces CRC-4 multiframe loss; search resumes after realignment.
// R24 - Alignment needs two signals within 8 ms spaced a multiple of 2 ms.
// R25 - Multiframe alignment signal in non-FAS bit 1 is 001011.
// R26 - The 400 ms interval is 3200 received 125 us frames.
package e1mfa_pkg;
  localparam int unsigned FRAME_US      = 125;
  localparam int unsigned IWT_MS        = 400;
  localparam int unsigned SRCH_MS       = 8;
  localparam int unsigned SPACE_MS      = 2;
  localparam int unsigned IWT_FRAMES    = IWT_MS * 1000 / FRAME_US;
  localparam int unsigned SRCH_FRAMES   = SRCH_MS * 1000 / FRAME_US;
  localparam int unsigned SPACE_FRAMES  = SPACE_MS * 1000 / FRAME_US;
  localparam logic [5:0]  MFA_PATTERN   = 6'h0b;
  localparam logic [3:0]  TS16_ALIGN    = 4'h0;
  localparam int unsigned ZERO_FRAMES   = 32;
  localparam logic [1:0]  ADDR_REFRAME  = 2'h0;
  localparam logic [1:0]  ADDR_SIGCFG   = 2'h1;
  localparam logic [1:0]  ADDR_SYSCFG   = 2'h2;
  localparam logic [1:0]  ADDR_STATUS   = 2'h3;
  localparam logic [7:0]  RST_CFG       = 8'h00;
  localparam int unsigned RF_CRC4       = 0;
  localparam int unsigned RF_IWK        = 3;
  localparam int unsigned RF_OFF        = 7;
  localparam int unsigned SC_ALARM      = 4;
  localparam int unsigned SC_NONFAS     = 5;
  localparam int unsigned SY_AIS        = 6;
  localparam int unsigned ST_SIG_LOST   = 1;
  localparam int unsigned ST_CRC_LOST   = 2;
  localparam int unsigned ST_IWK        = 3;
  typedef enum logic [3:0] {
    CS_LOST = 4'h1,
    CS_SRCH = 4'h2,
    CS_ALGN = 4'h4,
    CS_IWK  = 4'h8
  } e1mfa_crc_e;
  typedef enum logic [1:0] {
    SS_LOST = 2'h1,
    SS_ALGN = 2'h2
  } e1mfa_sig_e;
endpackage

/* File: testbench/e1mfa_far_end.sv */
module e1mfa_far_end (
  input  wire logic       clock_i,    // Bench clock
  input  wire logic       reset_i,    // Sync, active high
  input  wire logic       crc4_on_i,  // Send CRC-4 alignment
  input  wire logic [1:0] sig_mode_i, // 0 CAS, 1 zeros, 2 bad align
  output logic            frame_o,    // Frame strobe
  output logic            nfas_o,     // Non-FAS frame
  output logic            bit1_o,     // Slot 0 bit 1
  output logic      [7:0] ts16_o      // Slot 16 octet
);
  timeunit 1ns;
  timeprecision 1ps;
  // Non-FAS bit 1 across a CRC-4 multiframe, E bits at one
  localparam logic [7:0] NFAS_BITS = 8'h2f;
  logic [2:0] tick;
  logic [3:0] fnum;
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      tick    <= 3'h0;
      fnum    <= 4'h0;
      frame_o <= 1'b0;
      nfas_o  <= 1'b0;
      bit1_o  <= 1'b1;
      ts16_o  <= 8'h00;
    end else if (tick == 3'h7) begin
      tick    <= 3'h0;
      fnum    <= fnum + 4'h1;
      frame_o <= 1'b1;
      nfas_o  <= fnum[0];
      bit1_o  <= ~(fnum[0] & crc4_on_i) | NFAS_BITS[3'h7 - fnum[3:1]];
      ts16_o  <= (sig_mode_i == 2'h1) ? 8'h00 : (fnum != 4'h0) ? 8'h5a : (sig_mode_i == 2'h2) ? 8'h1d : 8'h0d;
    end else begin
      tick    <= tick + 3'h1;
      frame_o <= 1'b0;
      // Lines not held between frames
      nfas_o  <= ~nfas_o;
      bit1_o  <= ~bit1_o;
      ts16_o  <= ~ts16_o;
    end
  end
endmodule

/* File: testbench/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock_i = 1'b0;
  logic       reset_i = 1'b1;
  logic [1:0] addr_i = 2'h0;
  logic [7:0] wdata_i = 8'h00;
  logic       wr_i = 1'b0, rd_i = 1'b0, basic_aligned_i = 1'b0, loss_fas_i = 1'b0, loss_crc915_i = 1'b0;
  logic       reframe_req_i = 1'b0, path_reconfig_i = 1'b0, cand_differs_i = 1'b0, crc4_on = 1'b0;
  logic [1:0] sig_mode = 2'h0;
  logic       frame_i, cand_nfas_i, cand_bit1_i, tx_fas_i, lf;
  logic       new_search_o, adopt_cand_o, crc4_mfa_o, crc4_inhibit_o, e_bits_zero_o, sig_update_o;
  logic       rx_far_alarm_o, tx_mf_start_o, sys_ts16_ais_o;
  logic [2:0] rx_ctrl_o;
  logic [7:0] rdata_o, ts16_i, tx_ts16_f0_o;
  int         num_errors = 0, checks = 0, cyc = 0, fc = 0, ns_cnt = 0, ad_cnt = 0, su_cnt = 0, mf_f = 0, mf_n = 0;
  assign tx_fas_i = ~cand_nfas_i;
  always #12.5 clock_i = ~clock_i;
  e1mfa_far_end u_far (.clock_i, .reset_i, .crc4_on_i(crc4_on), .sig_mode_i(sig_mode), .frame_o(frame_i),
    .nfas_o(cand_nfas_i), .bit1_o(cand_bit1_i), .ts16_o(ts16_i));
  e1mfa_top u_dut (.clock_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .frame_i, .ts16_i,
    .basic_aligned_i, .loss_fas_i, .loss_crc915_i, .reframe_req_i, .path_reconfig_i, .cand_frame_i(frame_i),
    .cand_nfas_i, .cand_bit1_i, .cand_differs_i, .tx_frame_i(frame_i), .tx_fas_i, .new_search_o, .adopt_cand_o,
    .crc4_mfa_o, .crc4_inhibit_o, .e_bits_zero_o, .sig_update_o, .rx_ctrl_o, .rx_far_alarm_o, .tx_ts16_f0_o,
    .tx_mf_start_o, .sys_ts16_ais_o);
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (frame_i === 1'b1) fc <= fc + 1;
    if (frame_i === 1'b1) lf <= cand_nfas_i;
    if (new_search_o === 1'b1) ns_cnt <= ns_cnt + 1;
    if (adopt_cand_o === 1'b1) ad_cnt <= ad_cnt + 1;
    if (sig_update_o === 1'b1) su_cnt <= su_cnt + 1;
    if (tx_mf_start_o === 1'b1 && lf === 1'b1) mf_n <= mf_n + 1;
    if (tx_mf_start_o === 1'b1 && lf === 1'b0) mf_f <= mf_f + 1;
    if (cyc == 90000) begin
      num_errors++;
      give_verdict();
    end
  end
  task automatic give_verdict;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    step(1);
    wr_i <= 1'b0;
    step(1);
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    addr_i <= a;
    rd_i   <= 1'b1;
    step(1);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
    step(1);
  endtask
  task automatic chk_status(input logic [7:0] mask, input logic [7:0] exp);
    logic [7:0] v;
    rd(e1mfa_pkg::ADDR_STATUS, v);
    check("status", v & mask, exp);
  endtask
  task automatic t_reset;
    logic [7:0] v;
    check("rx_ctrl reset", rx_ctrl_o, 3'h7);
    chk_status(8'h06, 8'h06);
    wr(e1mfa_pkg::ADDR_SYSCFG, 8'h40);
    rd(e1mfa_pkg::ADDR_SYSCFG, v);
    check("syscfg", v, 8'h40);
    wr(e1mfa_pkg::ADDR_STATUS, 8'hff);
    chk_status(8'hff, 8'h06);
  endtask
  task automatic t_sig;
    int b;
    wr(e1mfa_pkg::ADDR_SIGCFG, 8'h35);
    step(2);
    check("tx_f0 lost", tx_ts16_f0_o, 8'h0d);
    check("ais lost", sys_ts16_ais_o, 1'b1);
    basic_aligned_i <= 1'b1;
    // Align on next frame 0, spares land one multiframe later
    step(8 * 36);
    chk_status(8'h02, 8'h00);
    check("tx_f0", tx_ts16_f0_o, 8'h09);
    check("ais", sys_ts16_ais_o, 1'b0);
    check("rx_ctrl", rx_ctrl_o, 3'h5);
    check("far alarm", rx_far_alarm_o, 1'b1);
    b = su_cnt;
    step(8 * 16);
    check("updates", 16'(su_cnt - b), 16'd15);
    sig_mode <= 2'h1;
    step(8 * 34);
    chk_status(8'h02, 8'h02);
    check("rx_ctrl lost", rx_ctrl_o, 3'h7);
    check("far alarm lost", rx_far_alarm_o, 1'b0);
    b = su_cnt;
    step(8 * 16);
    check("frozen", 16'(su_cnt - b), 16'd0);
    sig_mode <= 2'h0;
    step(8 * 20);
    chk_status(8'h02, 8'h00);
    sig_mode <= 2'h2;
    step(8 * 40);
    chk_status(8'h02, 8'h02);
    sig_mode <= 2'h0;
    step(8 * 20);
  endtask
  task automatic t_tx;
    int bn, bf;
    for (int i = 0; i < 2; i++) begin
      wr(e1mfa_pkg::ADDR_SIGCFG, (i == 0) ? 8'h35 : 8'h15);
      step(8 * 32);
      bn = mf_n;
      bf = mf_f;
      step(8 * 64);
      check("mf in nfas", 16'(mf_n - bn), (i == 0) ? 16'd4 : 16'd0);
      check("mf in fas", 16'(mf_f - bf), (i == 0) ? 16'd0 : 16'd4);
    end
  endtask
  task automatic t_crc;
    int b;
    cand_differs_i <= 1'b1;
    crc4_on        <= 1'b1;
    wr(e1mfa_pkg::ADDR_REFRAME, 8'h09);
    b = ad_cnt;
    step(8 * 80);
    check("mfa", crc4_mfa_o, 1'b1);
    check("adopt", 16'(ad_cnt - b), 16'd1);
    chk_status(8'h04, 8'h00);
    basic_aligned_i <= 1'b0;
    loss_fas_i      <= 1'b1;
    step(1);
    loss_fas_i <= 1'b0;
    step(3);
    check("mfa lost", crc4_mfa_o, 1'b0);
    chk_status(8'h06, 8'h06);
    step(8 * 80);
    check("no search unaligned", crc4_mfa_o, 1'b0);
    basic_aligned_i <= 1'b1;
    step(8 * 80);
    check("mfa again", crc4_mfa_o, 1'b1);
    cand_differs_i <= 1'b0;
  endtask
  task automatic iw_run(input logic second);
    int f0, b, n;
    basic_aligned_i <= 1'b0;
    loss_fas_i      <= ~second;
    loss_crc915_i   <= second;
    reframe_req_i   <= second;
    step(1);
    loss_fas_i    <= 1'b0;
    loss_crc915_i <= 1'b0;
    reframe_req_i <= 1'b0;
    step(3);
    check("iw cleared", crc4_inhibit_o, 1'b0);
    do step(1); while (frame_i !== 1'b1);
    basic_aligned_i <= 1'b1;
    step(1);
    f0 = fc;
    b  = ns_cnt;
    n  = 0;
    while (crc4_inhibit_o !== 1'b1 && n < 30000) begin
      step(1);
      n++;
    end
    check("iw frames", 16'(fc - f0), 16'd3200);
    check("e bits zero", e_bits_zero_o, 1'b1);
    check("new searches", 16'(ns_cnt - b >= 40), 16'd1);
    chk_status(8'h0c, 8'h0c);
  endtask
  task automatic t_iw;
    crc4_on <= 1'b0;
    wr(e1mfa_pkg::ADDR_REFRAME, 8'h0d);
    iw_run(1'b0);
    path_reconfig_i <= 1'b1;
    step(1);
    path_reconfig_i <= 1'b0;
    step(3);
    check("reconfig", crc4_inhibit_o, 1'b0);
    iw_run(1'b1);
    wr(e1mfa_pkg::ADDR_REFRAME, 8'h0c);
    step(3);
    check("non crc4 mode", crc4_inhibit_o, 1'b0);
  endtask
  initial begin
    step(6);
    reset_i <= 1'b0;
    step(1);
    t_reset();
    t_sig();
    t_tx();
    t_crc();
    t_iw();
    give_verdict();
  end
endmodule
